// File: logic/flash_host_defs.svh
// constants of the flash status polling and reset host controller
//
// Summary of operation
// - host reads whole byte twice; unchanged toggle means done, next read is data.
// - toggling after two reads: check timeout flag, if set re-test with two reads.
// - still toggling after timeout seen means failure; host writes the reset command.
// - host that leaves polling restarts the whole polling procedure on return.
// - after an erase timeout host issues reset before any new program or erase.
// - host reads erase-window flag before and after each added sector erase command.
// - sector protect needs elevated voltage on pins, then a write strobe pulse; the host has no sector protect operation.
// - host holds hardware reset 10 us during an algorithm, 500 ns otherwise.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS     40
`define CEIL_CYC(ns)      (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AT_LEAST_1(c)     (((c) < 1) ? 1 : (c))
`define T_ACCESS_NS       120
`define ACCESS_CYC        `AT_LEAST_1(`CEIL_CYC(`T_ACCESS_NS))
`define T_WE_LOW_NS       50
`define WE_LOW_CYC        `AT_LEAST_1(`CEIL_CYC(`T_WE_LOW_NS))
`define RESET_WIDTH_BUSY_NS 10000
`define RESET_WIDTH_BUSY_CYC `AT_LEAST_1(`CEIL_CYC(`RESET_WIDTH_BUSY_NS))
`define RESET_WIDTH_IDLE_NS 500
`define RESET_WIDTH_IDLE_CYC `AT_LEAST_1(`CEIL_CYC(`RESET_WIDTH_IDLE_NS))
`define RESET_HIGH_BEFORE_READ_NS 0
`define RESET_HIGH_CYC    `AT_LEAST_1(`CEIL_CYC(`RESET_HIGH_BEFORE_READ_NS))
`define POLL_TRIES        16
`define RESET_CMD_BYTE    8'hF0

// ****************************************************************
// register map (word index on the avalon slave)
// ****************************************************************
`define REG_CTRL          3'h0
`define REG_ADDR          3'h1
`define REG_WDATA         3'h2
`define REG_STATUS        3'h3
`define REG_RDATA         3'h4

// ****************************************************************
// bit positions
// ****************************************************************
`define ST_BUSY           0
`define ST_POLL_OK        1
`define ST_POLL_FAIL      2
`define ST_POLL_PENDING   3
`define ST_EW_REJECTED    4
`define ST_ALGO_RUNNING   5
`define ST_REFUSED        6
`define POLLING_STATUS_BIT 7
`define ACTIVITY_TOGGLE_BIT 6
`define TIMEOUT_FLAG_BIT  5
`define ERASE_WINDOW_FLAG_BIT 3
`define ERASE_SECTOR_TOGGLE_BIT 2
`define LOWEST_DATA_BIT   0

`endif

// File: logic/flash_host_pkg.sv
// types of the flash status polling host controller
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_READ      = 3'b001,
    OP_WRITE     = 3'b010,
    OP_POLL      = 3'b011,
    OP_RESET_CMD = 3'b100,
    OP_HW_RESET  = 3'b101,
    OP_ERASE_ADD = 3'b110
  } op_t;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_SINGLE  = 4'b0001,
    S_RD1     = 4'b0010,
    S_RD2     = 4'b0011,
    S_RD3     = 4'b0100,
    S_RD4     = 4'b0101,
    S_RST_CMD = 4'b0110,
    S_EW_RD1  = 4'b0111,
    S_EW_WR   = 4'b1000,
    S_EW_RD2  = 4'b1001,
    S_HRST    = 4'b1010,
    S_HRECOV  = 4'b1011
  } host_state_t;

  typedef enum logic [1:0] {
    C_IDLE   = 2'b00,
    C_SETUP  = 2'b01,
    C_STROBE = 2'b10,
    C_RECOV  = 2'b11
  } cyc_state_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [17:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } flash_bus_t;

endpackage : flash_host_pkg

// File: logic/flash_bus_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int ACC_CYC = `ACCESS_CYC,
  parameter int WE_CYC  = `WE_LOW_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  dq_i,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  output flash_bus_t       bus_o
);

  initial begin
    if (ACC_CYC < 1 || WE_CYC < 1 || ACC_CYC > 60 || WE_CYC > 60)
      $error("flash_bus_cycle: strobe counts out of range");
  end

  cyc_state_t cst;
  logic [5:0] cnt;
  logic       is_wr;
  logic [7:0] dq_meta;
  logic [7:0] dq_sync;

  // pin data crosses into the clock domain before anyone looks at it
  always_ff @(posedge clk_sys_i) begin
    dq_meta <= dq_i;
    dq_sync <= dq_meta;
  end

  // read holds oe low for access time plus the two synchroniser stages
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cst     <= C_IDLE;
      cnt     <= 6'h00;
      is_wr   <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 8'h00;
      bus_o   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 18'h00000,
                   dq_out: 8'h00, dq_oe: 1'b0};
    end else begin
      done_o <= 1'b0;
      case (cst)
        C_IDLE: begin
          if (start_i) begin
            is_wr        <= write_i;
            bus_o.addr   <= addr_i;
            bus_o.dq_out <= wdata_i;
            bus_o.dq_oe  <= write_i;
            bus_o.ce_n   <= 1'b0;
            cst          <= C_SETUP;
          end
        end
        C_SETUP: begin
          // any programming spans the strobe's fall to its rise
          if (is_wr) begin
            bus_o.we_n <= 1'b0;
            cnt        <= 6'(WE_CYC - 1);
          end else begin
            bus_o.oe_n <= 1'b0;
            cnt        <= 6'(ACC_CYC + 1);
          end
          cst <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
          end else begin
            if (!is_wr)
              rdata_o <= dq_sync;
            bus_o.we_n <= 1'b1;
            bus_o.oe_n <= 1'b1;
            cst        <= C_RECOV;
          end
        end
        C_RECOV: begin
          // separate chip select pulse per cycle so each read is its own toggle event
          bus_o.ce_n  <= 1'b1;
          bus_o.dq_oe <= 1'b0;
          done_o      <= 1'b1;
          cst         <= C_IDLE;
        end
        default: cst <= C_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_write_gating: assert property (!bus_o.we_n |-> bus_o.oe_n && !bus_o.ce_n)
    else $error("write strobe low without chip select or with output enable low");
  a_we_min_width: assert property ($fell(bus_o.we_n) |-> !bus_o.we_n [*2])
    else $error("write strobe pulse shorter than two cycles");

endmodule : flash_bus_cycle

// File: logic/flash_host_ctrl.sv
// host controller: avalon slave that polls and resets an external flash
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int POLL_TRIES = `POLL_TRIES,
  parameter int BUSY_CYC   = `RESET_WIDTH_BUSY_CYC,
  parameter int IDLE_CYC   = `RESET_WIDTH_IDLE_CYC,
  parameter int RH_CYC     = `RESET_HIGH_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  flash_dq_i,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic [17:0]      flash_addr_o,
  output logic             flash_rst_n_o
);

  initial begin
    if (POLL_TRIES < 1 || POLL_TRIES > 255 || BUSY_CYC < 1 || BUSY_CYC > 65535
        || IDLE_CYC < 1 || IDLE_CYC > BUSY_CYC || RH_CYC < 1 || RH_CYC > 65535)
      $error("flash_host_ctrl: parameter out of range");
  end

  // ****************************************************************
  // avalon slave
  // ****************************************************************
  logic        ack;
  logic [17:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rdata_reg;
  logic        take_wr;
  logic        order;
  op_t         order_op;

  // one wait cycle per access gives a registered read path
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign take_wr = avs_write_i & ack;
  assign order   = take_wr && (avs_address_i == `REG_CTRL);
  assign order_op = op_t'(avs_writedata_i[2:0]);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i)
      ack <= 1'b0;
    else
      ack <= (avs_read_i | avs_write_i) & ~ack;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_reg  <= 18'h00000;
      wdata_reg <= 8'h00;
    end else if (take_wr) begin
      if (avs_address_i == `REG_ADDR)
        addr_reg <= avs_writedata_i[17:0];
      else if (avs_address_i == `REG_WDATA)
        wdata_reg <= avs_writedata_i[7:0];
    end
  end

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  host_state_t st;
  logic        pend;
  logic        cyc_start;
  logic        cyc_write;
  logic [17:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic [7:0]  first_rd;
  logic [7:0]  tries;
  logic [15:0] hcnt;
  logic        poll_ok;
  logic        poll_fail;
  logic        poll_pending;
  logic        ew_rejected;
  logic        algo_running;
  logic        need_reset;
  logic        refused;
  logic        accept;
  logic        toggled;
  logic [31:0] status_word;
  logic        cyc_write_q;

  assign toggled = cyc_rdata[`ACTIVITY_TOGGLE_BIT] != first_rd[`ACTIVITY_TOGGLE_BIT];
  // no new program or erase order before the reset command
  assign accept = order && (st == S_IDLE) && !(need_reset &&
                  (order_op == OP_WRITE || order_op == OP_ERASE_ADD));

  always_comb begin
    cyc_write = 1'b0;
    cyc_addr  = addr_reg;
    cyc_wdata = wdata_reg;
    if (st == S_RST_CMD) begin
      cyc_write = 1'b1;
      cyc_wdata = `RESET_CMD_BYTE;
    end else if (st == S_EW_WR || (st == S_SINGLE && cyc_write_q)) begin
      cyc_write = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st           <= S_IDLE;
      pend         <= 1'b0;
      cyc_start    <= 1'b0;
      cyc_write_q  <= 1'b0;
      first_rd     <= 8'h00;
      tries        <= 8'h00;
      hcnt         <= 16'h0000;
      poll_ok      <= 1'b0;
      poll_fail    <= 1'b0;
      poll_pending <= 1'b0;
      ew_rejected  <= 1'b0;
      algo_running <= 1'b0;
      need_reset   <= 1'b0;
      refused      <= 1'b0;
      rdata_reg    <= 8'h00;
      flash_rst_n_o <= 1'b1;
    end else begin
      cyc_start <= 1'b0;
      if (order && !accept)
        refused <= 1'b1;
      // launch one bus cycle per sequencer step, act when it finishes
      if (st != S_IDLE && st != S_HRST && st != S_HRECOV && !pend) begin
        cyc_start <= 1'b1;
        pend      <= 1'b1;
      end
      case (st)
        S_IDLE: begin
          if (accept) begin
            refused      <= 1'b0;
            poll_ok      <= 1'b0;
            poll_fail    <= 1'b0;
            poll_pending <= 1'b0;
            cyc_write_q  <= (order_op == OP_WRITE);
            case (order_op)
              OP_READ, OP_WRITE: st <= S_SINGLE;
              // each poll order starts again from the first read pair
              OP_POLL: begin
                tries <= 8'(POLL_TRIES);
                st    <= S_RD1;
              end
              OP_RESET_CMD: st <= S_RST_CMD;
              OP_ERASE_ADD: begin
                ew_rejected <= 1'b0;
                st          <= S_EW_RD1;
              end
              OP_HW_RESET: begin
                // longer pulse when an algorithm may be running
                hcnt <= algo_running ? 16'(BUSY_CYC) : 16'(IDLE_CYC);
                flash_rst_n_o <= 1'b0;
                st   <= S_HRST;
              end
              default: st <= S_IDLE;
            endcase
          end
        end
        S_SINGLE: begin
          if (pend && cyc_done) begin
            pend <= 1'b0;
            if (cyc_write_q)
              algo_running <= 1'b1;
            else
              rdata_reg <= cyc_rdata;
            st <= S_IDLE;
          end
        end
        S_RD1, S_RD3: begin
          if (pend && cyc_done) begin
            pend     <= 1'b0;
            first_rd <= cyc_rdata;
            st       <= (st == S_RD1) ? S_RD2 : S_RD4;
          end
        end
        S_RD2: begin
          if (pend && cyc_done) begin
            pend      <= 1'b0;
            rdata_reg <= cyc_rdata;
            // unchanged toggle across two reads means finished
            if (!toggled) begin
              poll_ok      <= 1'b1;
              algo_running <= 1'b0;
              st           <= S_IDLE;
            // timeout seen: test the toggle once more
            end else if (cyc_rdata[`TIMEOUT_FLAG_BIT]) begin
              st <= S_RD3;
            end else if (tries == 8'h01) begin
              poll_pending <= 1'b1;
              st           <= S_IDLE;
            end else begin
              tries <= tries - 8'h01;
              st    <= S_RD1;
            end
          end
        end
        S_RD4: begin
          if (pend && cyc_done) begin
            pend      <= 1'b0;
            rdata_reg <= cyc_rdata;
            if (!toggled) begin
              poll_ok      <= 1'b1;
              algo_running <= 1'b0;
              st           <= S_IDLE;
            end else begin
              // failed operation, put the device back to array reads
              poll_fail  <= 1'b1;
              need_reset <= 1'b1;
              st         <= S_RST_CMD;
            end
          end
        end
        S_RST_CMD: begin
          if (pend && cyc_done) begin
            pend         <= 1'b0;
            need_reset   <= 1'b0;
            algo_running <= 1'b0;
            st           <= S_IDLE;
          end
        end
        S_EW_RD1: begin
          if (pend && cyc_done) begin
            pend     <= 1'b0;
            first_rd <= cyc_rdata;
            st       <= S_EW_WR;
          end
        end
        S_EW_WR: begin
          if (pend && cyc_done) begin
            pend         <= 1'b0;
            algo_running <= 1'b1;
            st           <= S_EW_RD2;
          end
        end
        S_EW_RD2: begin
          if (pend && cyc_done) begin
            pend      <= 1'b0;
            rdata_reg <= cyc_rdata;
            // window closed on the second check: command may be lost
            ew_rejected <= cyc_rdata[`ERASE_WINDOW_FLAG_BIT];
            st          <= S_IDLE;
          end
        end
        S_HRST: begin
          if (hcnt == 16'h0001) begin
            flash_rst_n_o <= 1'b1;
            hcnt          <= 16'(RH_CYC);
            st            <= S_HRECOV;
          end else begin
            hcnt <= hcnt - 16'h0001;
          end
        end
        S_HRECOV: begin
          if (hcnt == 16'h0001) begin
            algo_running <= 1'b0;
            need_reset   <= 1'b0;
            st           <= S_IDLE;
          end else begin
            hcnt <= hcnt - 16'h0001;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // register read path
  // ****************************************************************
  always_comb begin
    status_word = 32'h00000000;
    status_word[`ST_BUSY]         = (st != S_IDLE);
    status_word[`ST_POLL_OK]      = poll_ok;
    status_word[`ST_POLL_FAIL]    = poll_fail;
    status_word[`ST_POLL_PENDING] = poll_pending;
    status_word[`ST_EW_REJECTED]  = ew_rejected;
    status_word[`ST_ALGO_RUNNING] = algo_running;
    status_word[`ST_REFUSED]      = refused;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack) begin
      if (avs_address_i == `REG_ADDR)
        avs_readdata_o <= {14'h0000, addr_reg};
      else if (avs_address_i == `REG_WDATA)
        avs_readdata_o <= {24'h000000, wdata_reg};
      else if (avs_address_i == `REG_STATUS)
        avs_readdata_o <= status_word;
      else if (avs_address_i == `REG_RDATA)
        avs_readdata_o <= {24'h000000, rdata_reg};
      else
        avs_readdata_o <= 32'h00000000;
    end
  end

  // ****************************************************************
  // pin cycle engine
  // ****************************************************************
  flash_bus_t bus;

  flash_bus_cycle u_cycle (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .start_i   (cyc_start),
    .write_i   (cyc_write),
    .addr_i    (cyc_addr),
    .wdata_i   (cyc_wdata),
    .dq_i      (flash_dq_i),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .bus_o     (bus)
  );

  assign flash_ce_n_o  = bus.ce_n;
  assign flash_oe_n_o  = bus.oe_n;
  assign flash_we_n_o  = bus.we_n;
  assign flash_addr_o  = bus.addr;
  assign flash_dq_o    = bus.dq_out;
  assign flash_dq_oe_o = bus.dq_oe;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [15:0] low_run;
  logic        low_busy;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || flash_rst_n_o) begin
      low_run  <= 16'h0000;
      low_busy <= algo_running;
    end else begin
      low_run <= low_run + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_reset_width: assert property ($rose(flash_rst_n_o) |->
      (low_run >= 16'(IDLE_CYC)) && (!low_busy || low_run >= 16'(BUSY_CYC)))
    else $error("hardware reset pulse too short");
  a_two_reads_first: assert property ($rose(st == S_RD2) |-> $past(st) == S_RD1)
    else $error("poll decision without a preceding first read");
  a_done_on_equal: assert property (st == S_RD2 && pend && cyc_done && !toggled
      |=> poll_ok && st == S_IDLE)
    else $error("steady toggle not reported as done");
  a_recheck_timeout: assert property (st == S_RD2 && pend && cyc_done && toggled
      && cyc_rdata[`TIMEOUT_FLAG_BIT] |=> st == S_RD3)
    else $error("timeout seen but toggle not re-tested");
  a_fail_resets: assert property ($rose(poll_fail) |-> st == S_RST_CMD
      ##[1:20] (st == S_RST_CMD && flash_we_n_o == 1'b0 && flash_dq_o == `RESET_CMD_BYTE))
    else $error("failed poll not followed by reset command");
  a_restart_top: assert property ($rose(st == S_RD1) |->
      $past(st) == S_IDLE || $past(st) == S_RD2)
    else $error("poll entered other than at its first step");
  a_block_after_fail: assert property (need_reset && order
      && (order_op == OP_WRITE || order_op == OP_ERASE_ADD) |=> st != S_SINGLE && st != S_EW_RD1)
    else $error("program or erase started before reset command");
  a_ew_record: assert property (st == S_EW_RD2 && pend && cyc_done
      |=> ew_rejected == $past(cyc_rdata[`ERASE_WINDOW_FLAG_BIT]))
    else $error("erase window flag not recorded after added command");

  c_poll_ok: cover property (st == S_RD2 ##1 poll_ok);
  c_poll_fail: cover property ($rose(poll_fail));
  c_hw_reset: cover property ($rose(flash_rst_n_o));
  c_ew_rejected: cover property ($rose(ew_rejected));

endmodule : flash_host_ctrl

// File: test/flash_dev_model.sv
// behavioural flash device model facing the host controller pins
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int         BUSY_READS = 3,
  parameter logic [3:0] PROT_SEC   = 4'hC
) (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        stuck_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  din_i,
  output logic [7:0]       dq_o
);
  logic [7:0] mem [0:255];
  logic [7:0] wdat;
  logic [7:0] waddr;
  logic       tog;
  logic       tmo;
  logic       lock;
  logic       ers;
  logic       ew;
  logic       e2;
  logic       idm;
  int         left;
  realtime    t_fall;

  // array read mode with nothing pending
  initial begin
    tog = 1'b0;
    tmo = 1'b0;
    lock = 1'b0;
    ers = 1'b0;
    ew = 1'b0;
    e2 = 1'b0;
    idm = 1'b0;
    left = 0;
    dq_o = 8'hA5;
    foreach (mem[i]) mem[i] = 8'hFF;
  end

  always @(negedge we_n_i) t_fall = $realtime;

  always @(posedge we_n_i) begin
    // only a clean strobe with output enable high writes
    if (!ce_n_i && oe_n_i && ($realtime - t_fall) >= 5.0) begin
      // only the reset byte is heard while timed out; while busy, the reset byte or an added sector erase
      if (din_i == 8'hF0) begin
        lock = 1'b0;
        tmo = 1'b0;
        idm = 1'b0;
        left = 0;
      // open window: a further sector erase joins the running erase
      end else if (ers && !ew && left > 0 && din_i == 8'h30) begin
        left = BUSY_READS;
      end else if (!lock && left == 0 && din_i == 8'h90) begin
        idm = 1'b1;
      end else if (!lock && left == 0) begin
        waddr = addr_i[7:0];
        wdat = din_i;
        ers = (din_i == 8'h30);
        ew = 1'b0;
        lock = stuck_i;
        left = stuck_i ? 0 : BUSY_READS;
      end
    end
  end

  always @(negedge oe_n_i) begin
    if (!ce_n_i) begin
      // status bits while an algorithm runs
      if (lock || left > 0) begin
        // activity bit flips anywhere, sector bit only inside the erase
        tog = ~tog;
        if (ers && addr_i[7:4] == waddr[7:4]) e2 = ~e2;
        tmo = lock;
        // window flag low on the first status read, high afterwards
        dq_o = {!ers && !wdat[7], tog, tmo, 1'b0, ers && ew, e2, 2'b00};
        ew = 1'b1;
        if (left > 0) begin
          left--;
          if (left == 0 && ers) begin
            for (int i = 0; i < 16; i++) mem[{waddr[7:4], 4'(i)}] = 8'hFF;
          // a protected sector keeps its contents on program, an erase still clears it
          end else if (left == 0 && waddr[7:4] != PROT_SEC) begin
            mem[waddr] = wdat;
          end
        end
      // id-select high shows protection on the lowest bit
      end else if (idm) begin
        dq_o = {7'h00, addr_i[1] && addr_i[7:4] == PROT_SEC};
      end else begin
        dq_o = mem[addr_i[7:0]];
      end
    end
  end

  // released bus shows the inverse so a stale value never passes
  always @(posedge oe_n_i) dq_o = ~dq_o;

  // hardware reset drops any pending or locked work
  always @(negedge rst_n_i) begin
    lock = 1'b0;
    tmo = 1'b0;
    idm = 1'b0;
    left = 0;
  end
endmodule : flash_dev_model

// File: test/flash_host_ctrl_test.sv
// self-checking bench of the flash host controller
`timescale 1ns/1ps
`include "flash_host_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module flash_host_ctrl_test;
  import flash_host_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [2:0]  adr = 3'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wait_req;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic        rst_n;
  logic        dq_oe;
  logic [17:0] faddr;
  logic        stuck = 1'b0;
  logic [31:0] q;
  logic [31:0] st;
  int          err_total = 0;
  int          checked = 0;
  int          lowcnt = 0;

  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (rst_n === 1'b0) lowcnt++;
  always @(negedge we_n) `CHK(dq_oe, 1'b1)

  flash_host_ctrl #(.BUSY_CYC(20)) i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req), .flash_dq_i(dq_in),
    .flash_dq_o(dq_out), .flash_dq_oe_o(dq_oe), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .flash_addr_o(faddr), .flash_rst_n_o(rst_n));
  flash_dev_model i_dev (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(rst_n),
    .stuck_i(stuck), .addr_i(faddr), .din_i(dq_out), .dq_o(dq_in));

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic av_xfer(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_sys_i);
    while (wait_req !== 1'b0 && n < 50) begin
      @(posedge clk_sys_i);
      n++;
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys_i);
  endtask : av_xfer

  task automatic wait_idle();
    int n;
    for (n = 0; n < 400; n++) begin
      av_xfer(1'b0, `REG_STATUS, 32'h0);
      st = q;
      if (st[`ST_BUSY] === 1'b0) return;
    end
    err_total++;
    finish_test();
  endtask : wait_idle

  task automatic do_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
    av_xfer(1'b1, `REG_ADDR, {14'h0, a});
    av_xfer(1'b1, `REG_WDATA, {24'h0, d});
    av_xfer(1'b1, `REG_CTRL, {29'h0, op});
    wait_idle();
  endtask : do_op

  task automatic rd_arr(input logic [17:0] a);
    do_op(3'h1, a, 8'h00);
    av_xfer(1'b0, `REG_RDATA, 32'h0);
  endtask : rd_arr

  initial begin
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    av_xfer(1'b0, 3'h7, 32'h0);
    `CHK(q, 32'h0)
    do_op(3'h2, 18'h00010, 8'h5A);
    do_op(3'h3, 18'h00010, 8'h00);
    `CHK(st[2:1], 2'b01)
    rd_arr(18'h00010);
    `CHK(q[7:0], 8'h5A)
    stuck <= 1'b1;
    do_op(3'h2, 18'h00020, 8'h33);
    stuck <= 1'b0;
    do_op(3'h3, 18'h00020, 8'h00);
    `CHK(st[2:1], 2'b10)
    rd_arr(18'h00020);
    `CHK(q[7:0], 8'hFF)
    lowcnt = 0;
    av_xfer(1'b1, `REG_CTRL, 32'h5);
    av_xfer(1'b1, `REG_CTRL, 32'h2);
    wait_idle();
    `CHK(st[`ST_REFUSED], 1'b1)
    `CHK(lowcnt >= `RESET_WIDTH_IDLE_CYC, 1'b1)
    rd_arr(18'h00010);
    `CHK(q[7:0], 8'h5A)
    do_op(3'h2, 18'h00030, 8'h11);
    lowcnt = 0;
    do_op(3'h5, 18'h00000, 8'h00);
    `CHK(lowcnt >= 20, 1'b1)
    rd_arr(18'h00030);
    `CHK(q[7:0], 8'hFF)
    do_op(3'h2, 18'h000C4, 8'h12);
    do_op(3'h3, 18'h000C4, 8'h00);
    rd_arr(18'h000C4);
    `CHK(q[7:0], 8'hFF)
    do_op(3'h2, 18'h00000, 8'h90);
    rd_arr(18'h000C2);
    `CHK(q[7:0], 8'h01)
    rd_arr(18'h00012);
    `CHK(q[7:0], 8'h00)
    do_op(3'h4, 18'h00000, 8'h00);
    rd_arr(18'h00010);
    `CHK(q[7:0], 8'h5A)
    do_op(3'h6, 18'h00010, 8'h30);
    `CHK(st[`ST_EW_REJECTED], 1'b0)
    do_op(3'h6, 18'h00010, 8'h30);
    `CHK(st[`ST_EW_REJECTED], 1'b1)
    rd_arr(18'h00010);
    `CHK(q[7:0], 8'hFF)
    finish_test();
  end
endmodule : flash_host_ctrl_test
